/* rtl/jlh_decode.sv */
// Purpose: execute zero jump, display on/off, ram loads, hold enables
// Assumes: apb slave, zero wait, one instruction per instr write
// Notes: instruction writes are ignored while hold mode is active
`timescale 1ns/100ps
`include "jlh_consts.svh"

module jlh_decode
   import jlh_pkg::*;
#(
   parameter int RAM_AW = 7,
   parameter int PC_W = 11
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // wake sources
   input jlh_wake_type wake,
   // core outputs
   output logic display_en,
   output logic hold_active,
   output logic irq
);

   localparam int RAM_DEPTH = 1 << RAM_AW;

   // the opcode fields fix these widths
   if (RAM_AW != 7) begin : g_chk_aw
      $error("RAM_AW must be 7");
   end
   if (PC_W != 11) begin : g_chk_pc
      $error("PC_W must be 11");
   end

   // architectural state
   logic [3:0] accumulator_r;
   logic carry_flag_r;
   logic zero_flag_r;
   logic [PC_W-1:0] pc_r;
   logic [7:0] hold_release_enable_r;
   logic [15:0] instr_r;
   logic display_en_r;
   logic hold_r;
   logic body_int_r;
   logic [2:0] stat_r;
   logic [2:0] stat_nxt;
   logic [2:0] mask_r;
   logic [RAM_AW-1:0] ram_addr_r;
   logic int_pin_r;
   logic irq_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   // data ram, no reset: contents are software owned
   logic [3:0] ram_mem [RAM_DEPTH];

   // bus decode
   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic mapped;
   logic [31:0] rd_mux;

   assign setup = psel & ~penable;
   assign access = psel & penable & pready_r;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         `JLH_OFS_INSTR: begin
            rd_mux[15:0] = instr_r;
         end
         `JLH_OFS_ACC: begin
            rd_mux[3:0] = accumulator_r;
         end
         `JLH_OFS_FLAGS: begin
            rd_mux[`JLH_FLG_CF] = carry_flag_r;
            rd_mux[`JLH_FLG_ZF] = zero_flag_r;
         end
         `JLH_OFS_PC: begin
            rd_mux[PC_W-1:0] = pc_r;
         end
         `JLH_OFS_HOLD_EN: begin
            rd_mux[7:0] = hold_release_enable_r;
         end
         `JLH_OFS_CTRL: begin
            rd_mux[`JLH_CTL_HOLD] = hold_r;
            rd_mux[`JLH_CTL_BODY] = body_int_r;
         end
         `JLH_OFS_STAT: begin
            rd_mux[2:0] = stat_r;
         end
         `JLH_OFS_MASK: begin
            rd_mux[2:0] = mask_r;
         end
         `JLH_OFS_RAM_ADDR: begin
            rd_mux[RAM_AW-1:0] = ram_addr_r;
         end
         `JLH_OFS_RAM_DATA: begin
            rd_mux[3:0] = ram_mem[ram_addr_r];
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // answer in the first access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~mapped;
         if (setup && !pwrite) begin
            prdata_r <= rd_mux;
         end
      end
   end

   // instruction decode
   jlh_dec_type dec;
   logic exec;

   jlh_idec u_idec (
      .instr(pwdata[15:0]),
      .dec(dec)
   );

   // core is stopped in hold, so an instruction then is dropped
   assign exec = wr & hit(paddr, `JLH_OFS_INSTR) & ~hold_r;

   logic jump_taken;
   assign jump_taken = exec && dec.op == op_jz && accumulator_r == 4'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_r <= 16'h0000;
      end else if (exec) begin
         instr_r <= pwdata[15:0];
      end
   end

   // program counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r <= `JLH_PC_RST;
      end else if (exec) begin
         if (jump_taken) begin
            pc_r <= dec.target;
         end else begin
            pc_r <= pc_r + 11'h001;
         end
      end else if (wr && hit(paddr, `JLH_OFS_PC)) begin
         pc_r <= pwdata[PC_W-1:0];
      end
   end

   // display enable, set by display on, held until display off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         display_en_r <= 1'b0;
      end else if (exec && dec.op == op_disp_on) begin
         display_en_r <= 1'b1;
      end else if (exec && dec.op == op_disp_off) begin
         display_en_r <= 1'b0;
      end
   end

   // accumulator and zero flag
   logic [3:0] ram_q;
   assign ram_q = ram_mem[dec.ram_addr];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accumulator_r <= `JLH_ACC_RST;
         zero_flag_r <= 1'b0;
      end else if (exec && dec.op == op_ld_acc) begin
         accumulator_r <= ram_q;
         zero_flag_r <= ram_q == 4'h0;
      end else begin
         if (wr && hit(paddr, `JLH_OFS_ACC)) begin
            accumulator_r <= pwdata[3:0];
         end
         if (wr && hit(paddr, `JLH_OFS_FLAGS)) begin
            zero_flag_r <= pwdata[`JLH_FLG_ZF];
         end
      end
   end

   // carry flag: the carry load and a flags write touch it here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carry_flag_r <= 1'b0;
      end else if (exec && dec.op == op_ld_cf) begin
         carry_flag_r <= ram_q[0];
      end else if (wr && hit(paddr, `JLH_OFS_FLAGS)) begin
         carry_flag_r <= pwdata[`JLH_FLG_CF];
      end
   end

   // hold release enables, reserved bits stay zero
   localparam logic [7:0] HEF_RST = `JLH_HEF_RST;
   localparam logic [7:0] HEF_USED = `JLH_HEF_USED;
   for (genvar i = 0; i < 8; i++) begin : g_hef
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            hold_release_enable_r[i] <= HEF_RST[i];
         end else if (exec && dec.op == op_hold_en) begin
            hold_release_enable_r[i] <= dec.imm[i] & HEF_USED[i];
         end
      end
   end

   // wake sources, bit positions match the immediate
   logic int_fall;
   logic [7:0] src;
   logic wake_hit;

   assign int_fall = int_pin_r & ~wake.int_pin;

   always_comb begin
      src = 8'h00;
      src[`JLH_HEF_DIV0] = wake.div0_ovf;
      src[`JLH_HEF_TMR0] = wake.tmr0_udf;
      src[`JLH_HEF_PORT] = wake.port_chg;
      src[`JLH_HEF_SRC4] = body_int_r ? int_fall : wake.div1_ovf;
      src[`JLH_HEF_TMR1] = wake.tmr1_udf;
   end

   // a source only wakes while its enable is set
   assign wake_hit = hold_r & |(src & hold_release_enable_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_pin_r <= 1'b1;
      end else begin
         int_pin_r <= wake.int_pin;
      end
   end

   // hold mode and body option
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_r <= 1'b0;
      end else if (wake_hit) begin
         hold_r <= 1'b0;
      end else if (wr && hit(paddr, `JLH_OFS_CTRL)) begin
         hold_r <= pwdata[`JLH_CTL_HOLD];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         body_int_r <= 1'b0;
      end else if (wr && hit(paddr, `JLH_OFS_CTRL)) begin
         body_int_r <= pwdata[`JLH_CTL_BODY];
      end
   end

   // status: read clears, a new event in that cycle survives
   logic bad_op;
   assign bad_op = exec && dec.op == op_none;

   always_comb begin
      stat_nxt = stat_r;
      if (rd && hit(paddr, `JLH_OFS_STAT)) begin
         stat_nxt = 3'h0;
      end
      if (jump_taken) begin
         stat_nxt[`JLH_ST_JUMP] = 1'b1;
      end
      if (wake_hit) begin
         stat_nxt[`JLH_ST_WAKE] = 1'b1;
      end
      if (bad_op) begin
         stat_nxt[`JLH_ST_BAD] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= `JLH_ST_RST;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= 3'h0;
      end else if (wr && hit(paddr, `JLH_OFS_MASK)) begin
         mask_r <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_nxt & mask_r);
      end
   end

   // data ram access window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ram_addr_r <= '0;
      end else if (wr && hit(paddr, `JLH_OFS_RAM_ADDR)) begin
         ram_addr_r <= pwdata[RAM_AW-1:0];
      end
   end

   always_ff @(posedge pclk) begin
      if (wr && hit(paddr, `JLH_OFS_RAM_DATA)) begin
         ram_mem[ram_addr_r] <= pwdata[3:0];
      end
   end

   // outputs straight from flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign display_en = display_en_r;
   assign hold_active = hold_r;
   assign irq = irq_r;

endmodule

/* rtl/jlh_idec.sv */
// Purpose: opcode decoder for the decode slice
// Assumes: 16-bit instruction word, msb first as printed
// Notes: purely combinational
`timescale 1ns/100ps
`include "jlh_consts.svh"

module jlh_idec
   import jlh_pkg::*;
(
   // instruction in
   input wire logic [15:0] instr,
   // decoded fields out
   output jlh_dec_type dec
);

   function automatic jlh_op_type classify(input logic [15:0] w);
      jlh_op_type r;
      r = op_none;
      if (w[15:11] == `JLH_OP_JZ) begin
         r = op_jz;
      end else if (w == `JLH_OP_DISP_ON) begin
         r = op_disp_on;
      end else if (w == `JLH_OP_DISP_OFF) begin
         r = op_disp_off;
      end else if (w[15:7] == `JLH_OP_LD_ACC) begin
         r = op_ld_acc;
      end else if (w[15:7] == `JLH_OP_LD_CF) begin
         r = op_ld_cf;
      end else if (w[15:8] == `JLH_OP_HOLD_EN) begin
         r = op_hold_en;
      end
      return r;
   endfunction

   always_comb begin
      dec.op = classify(instr);
      dec.target = instr[10:0];
      dec.ram_addr = instr[6:0];
      dec.imm = instr[7:0];
   end

endmodule

/* shared/jlh_consts.svh */
// Purpose: offsets, field positions, opcodes and reset values
// Assumes: included by the decode slice and its opcode decoder
// Notes: one word per register on the apb side
`ifndef JLH_CONSTS_SVH
`define JLH_CONSTS_SVH

// register byte offsets
`define JLH_OFS_INSTR 8'h00
`define JLH_OFS_ACC 8'h04
`define JLH_OFS_FLAGS 8'h08
`define JLH_OFS_PC 8'h0c
`define JLH_OFS_HOLD_EN 8'h10
`define JLH_OFS_CTRL 8'h14
`define JLH_OFS_STAT 8'h18
`define JLH_OFS_MASK 8'h1c
`define JLH_OFS_RAM_ADDR 8'h20
`define JLH_OFS_RAM_DATA 8'h24

// opcode fields
`define JLH_OP_JZ 5'h1c
`define JLH_OP_DISP_ON 16'h0200
`define JLH_OP_DISP_OFF 16'h0201
`define JLH_OP_LD_ACC 9'h09d
`define JLH_OP_LD_CF 9'h0b0
`define JLH_OP_HOLD_EN 8'h41

// hold release enable bits that exist
`define JLH_HEF_USED 8'h97
`define JLH_HEF_DIV0 0
`define JLH_HEF_TMR0 1
`define JLH_HEF_PORT 2
`define JLH_HEF_SRC4 4
`define JLH_HEF_TMR1 7

// flag, control and status bits
`define JLH_FLG_CF 0
`define JLH_FLG_ZF 1
`define JLH_CTL_HOLD 0
`define JLH_CTL_BODY 1
`define JLH_ST_JUMP 0
`define JLH_ST_WAKE 1
`define JLH_ST_BAD 2

// reset values
`define JLH_ACC_RST 4'h0
`define JLH_PC_RST 11'h000
`define JLH_HEF_RST 8'h00
`define JLH_ST_RST 3'h0

`endif

/* shared/jlh_pkg.sv */
// Purpose: types shared by the decode slice
// Assumes: nothing
// Notes: constants live in jlh_consts.svh
package jlh_pkg;

   typedef enum logic [2:0] {
      op_none,
      op_jz,
      op_disp_on,
      op_disp_off,
      op_ld_acc,
      op_ld_cf,
      op_hold_en
   } jlh_op_type;

   // wake event sources, one cycle pulses except int_pin
   typedef struct packed {
      logic div0_ovf;
      logic tmr0_udf;
      logic port_chg;
      logic div1_ovf;
      logic int_pin;
      logic tmr1_udf;
   } jlh_wake_type;

   typedef struct packed {
      jlh_op_type op;
      logic [10:0] target;
      logic [6:0] ram_addr;
      logic [7:0] imm;
   } jlh_dec_type;

endpackage

/* tb/jlh_decode_monitor.sv */
// Purpose: port checks for the decode slice
// Assumes: zero wait apb, one clock
// Notes: bound onto every jlh_decode
`timescale 1ns/100ps
`include "jlh_consts.svh"
module jlh_decode_monitor
   import jlh_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // core
   input wire jlh_wake_type wake,
   input wire logic display_en,
   input wire logic hold_active,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence instr_s(logic [15:0] c);
      psel && penable && pwrite && paddr == `JLH_OFS_INSTR && pwdata[15:0] == c && !hold_active;
   endsequence
   ans_slot_a: assert property (setup_s |=> pready) else $error("no answer after setup");
   ans_once_a: assert property (pready |=> !pready) else $error("answer held too long");
   bad_addr_a: assert property (setup_s ##0 !pwrite && paddr > 8'h24 |=> pslverr && prdata == 0)
      else $error("unmapped read not refused");
   good_addr_a: assert property (setup_s ##0 paddr <= 8'h24 && paddr[1:0] == 0 |=> !pslverr)
      else $error("mapped access refused");
   disp_on_a: assert property (instr_s(16'h0200) |=> display_en)
      else $error("display did not turn on");
   disp_off_a: assert property (instr_s(16'h0201) |=> !display_en)
      else $error("display did not turn off");
   disp_keep_a: assert property (!(psel && penable) |=> $stable(display_en))
      else $error("display changed without a command");
   hold_rise_a: assert property ($rose(hold_active) |->
      $past(psel && penable && pwrite && paddr == `JLH_OFS_CTRL && pwdata[0]))
      else $error("hold entered without a control write");
   hold_keep_a: assert property (hold_active && wake == 6'h02 && $past(wake.int_pin) && !psel
      |=> hold_active)
      else $error("hold released with no wake event");
endmodule
bind jlh_decode jlh_decode_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .wake, .display_en, .hold_active, .irq);

/* tb/tb_top.sv */
// Purpose: self-checking bench for the decode slice
// Assumes: zero wait apb, single clock
// Notes: bench model tracks pc, accumulator, flags and ram
`timescale 1ns/100ps
`include "jlh_consts.svh"
module tb_top
   import jlh_pkg::*;
;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00, m_hef = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'h1a6e57c3;
   logic pready, pslverr, display_en, hold_active, irq, rerr;
   logic m_disp = 1'h0, m_cf = 1'h0, m_zf = 1'h0;
   jlh_wake_type wake = 6'h02;
   logic [3:0] m_acc = 4'h0, ram [128];
   logic [10:0] m_pc = 11'h000;
   int error_cnt = 0, n_tests = 0, cyc = 0;

   always #5 pclk = ~pclk;

   jlh_decode DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .wake, .display_en, .hold_active, .irq);

   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic chk(logic [31:0] s, logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   // pready and prdata are read before this edge's updates land
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n == 20) error_cnt++;
      rdat = prdata;
      rerr = pslverr;
      @(posedge pclk);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(rdat, e);
   endtask

   task automatic exec(logic [15:0] i);
      bus(1'h1, `JLH_OFS_INSTR, {16'h0, i});
      if (i[15:11] == 5'h1c && m_acc == 4'h0) m_pc = i[10:0];
      else m_pc = m_pc + 11'h001;
      if (i[15:7] == 9'h09d) m_acc = ram[i[6:0]];
      if (i[15:7] == 9'h09d) m_zf = (ram[i[6:0]] == 4'h0);
      if (i[15:7] == 9'h0b0) m_cf = ram[i[6:0]][0];
      if (i[15:8] == 8'h41) m_hef = i[7:0] & 8'h97;
      if (i == 16'h0200) m_disp = 1'h1;
      if (i == 16'h0201) m_disp = 1'h0;
      rd(`JLH_OFS_PC, {21'h0, m_pc});
      rd(`JLH_OFS_ACC, {28'h0, m_acc});
      rd(`JLH_OFS_FLAGS, {30'h0, m_zf, m_cf});
      rd(`JLH_OFS_HOLD_EN, {24'h0, m_hef});
      chk(display_en, m_disp);
   endtask

   // disabled case keeps every other source enabled to expose a wrong bit mapping
   task automatic wake_try(int b, logic en, logic body);
      jlh_wake_type p;
      case (b)
         0: p = 6'h20;
         1: p = 6'h10;
         2: p = 6'h08;
         4: p = body ? 6'h02 : 6'h04;
         default: p = 6'h01;
      endcase
      bus(1'h1, `JLH_OFS_CTRL, {30'h0, body, 1'h0});
      exec({8'h41, en ? 8'h01 << b : 8'h97 & ~(8'h01 << b)});
      bus(1'h1, `JLH_OFS_CTRL, {30'h0, body, 1'h1});
      @(negedge pclk);
      chk(hold_active, 1'h1);
      @(posedge pclk);
      wake <= 6'h02 ^ p;
      @(posedge pclk);
      wake <= 6'h02;
      repeat (3) @(negedge pclk);
      chk(hold_active, !en);
      chk(irq, en);
      bus(1'h0, `JLH_OFS_STAT, 32'h0);
      chk(rdat[1], en);
      repeat (2) @(negedge pclk);
      chk(irq, 1'h0);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      rd(`JLH_OFS_PC, 32'h0);
      rd(`JLH_OFS_HOLD_EN, 32'h0);
      exec(16'h0200);
      exec(16'h0201);
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         ram[seed[6:0]] = (k == 0) ? 4'h0 : seed[11:8];
         bus(1'h1, `JLH_OFS_RAM_ADDR, {25'h0, seed[6:0]});
         bus(1'h1, `JLH_OFS_RAM_DATA, {28'h0, ram[seed[6:0]]});
         exec({9'h09d, seed[6:0]});
         exec({5'h1c, seed[26:16]});
         exec({9'h0b0, seed[6:0]});
         exec({8'h41, seed[31:24]});
      end
      chk(irq, 1'h0);
      bus(1'h1, `JLH_OFS_MASK, 32'h2);
      for (int v = 0; v < 4; v++) begin
         wake_try(0, v[0], v[1]);
         wake_try(1, v[0], v[1]);
         wake_try(2, v[0], v[1]);
         wake_try(4, v[0], v[1]);
         wake_try(7, v[0], v[1]);
      end
      // taken jump and unknown code raise their status bits
      bus(1'h1, `JLH_OFS_MASK, 32'h5);
      bus(1'h1, `JLH_OFS_ACC, 32'h0);
      m_acc = 4'h0;
      exec({5'h1c, seed[26:16]});
      exec(16'hffff);
      chk(irq, 1'h1);
      rd(`JLH_OFS_STAT, 32'h5);
      bus(1'h0, 8'h40, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      give_verdict();
   end
endmodule
